// file: sctc_host_model.sv
// Two-wire host model that writes and reads 16-bit registers.
// Assumes the bench resolves SDA with a pull-up.
`timescale 1ns/100ps
`default_nettype none

module sctc_host_model (
  input  wire logic clk,      // Bench clock
  output logic      scl,      // Serial clock
  output logic      sda_drv,  // Data, 1 releases the wire
  input  wire logic sda_wire  // Resolved data level
);
  // Idle bus
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic hp(input int n);
    repeat (n) @(posedge clk);
  endtask : hp

  // One bit; data moves only while the clock is low
  task automatic bit_io(input logic v, output logic r);
    hp(2);
    sda_drv <= v;
    hp(3);
    scl <= 1'b1;
    hp(5);
    r = sda_wire;
    scl <= 1'b0;
  endtask : bit_io

  task automatic start;
    hp(5);
    sda_drv <= 1'b0;
    hp(5);
    scl <= 1'b0;
  endtask : start

  task automatic stop;
    hp(2);
    sda_drv <= 1'b0;
    hp(3);
    scl <= 1'b1;
    hp(5);
    sda_drv <= 1'b1;
    hp(5);
  endtask : stop

  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask : send

  task automatic recv(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask : recv

  task automatic probe(input logic [7:0] sa, output logic ack);
    start;
    send(sa, ack);
    stop;
  endtask : probe

  // Word write: pointer, high byte, low byte
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic k;
    start;
    send({sctc_pkg::SLAVE_ADDR_DEFAULT, 1'b0}, k);
    send(a, k);
    send(d[15:8], k);
    send(d[7:0], k);
    stop;
  endtask : wr

  // Word read: set pointer, then fetch high and low byte
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    logic k;
    start;
    send({sctc_pkg::SLAVE_ADDR_DEFAULT, 1'b0}, k);
    send(a, k);
    stop;
    start;
    send({sctc_pkg::SLAVE_ADDR_DEFAULT, 1'b1}, k);
    recv(1'b0, d[15:8]);
    recv(1'b1, d[7:0]);
    stop;
  endtask : rd
endmodule : sctc_host_model

`default_nettype wire

// file: sctc_monitor.sv
// Checker of conversion timing, captured values and fault flags.
// Bound into sctc_top; sees the top module's ports only.
`timescale 1ns/100ps
`default_nettype none

module sctc_monitor (
  input wire logic        REF_CLK,         // Clock
  input wire logic        RST_N,           // Sync reset, low
  input wire logic        CONV_START,      // Request
  input wire logic [15:0] CH2_SETTLE,      // Ch2 settle count
  input wire logic [15:0] CH3_SETTLE,      // Ch3 settle count
  input wire logic        AMP_FAULT_EN,    // Fault enable
  input wire logic        SETTLING,        // Settle phase
  input wire logic        CONVERTING,      // Conversion phase
  input wire logic        CONV_BEGIN,      // Start pulse
  input wire logic        CONV_DONE,       // End pulse
  input wire logic [1:0]  ACTIVE_CH,       // Captured channel
  input wire logic [15:0] ACTIVE_OFFSET,   // Captured offset
  input wire logic [15:0] ACTIVE_INTERVAL, // Captured interval
  input wire logic [3:0]  AMP_FAULTS       // Fault flags
);
  logic [31:0] scnt_q;
  logic [31:0] ccnt_q;
  logic [15:0] pin_settle;
  logic [31:0] exp_settle;

  // Expected settle length of pin-fed channels
  assign pin_settle = ACTIVE_CH[0] ? CH3_SETTLE : CH2_SETTLE;
  assign exp_settle = (pin_settle < 16'h0002) ? 32'h20 :
                      {12'h0, pin_settle, 4'h0};

  // Phase length counters
  always_ff @(posedge REF_CLK) begin
    scnt_q <= SETTLING ? scnt_q + 32'h1 : 32'h0;
    ccnt_q <= CONVERTING ? ccnt_q + 32'h1 : 32'h0;
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  conv_len_a: assert property (
    $fell(CONVERTING) |-> ccnt_q == {12'h0, ACTIVE_INTERVAL, 4'h0})
    else $error("conversion length wrong");
  done_pulse_a: assert property (
    CONV_DONE == $fell(CONVERTING)) else $error("done pulse misplaced");
  settle_len_a: assert property (
    $fell(SETTLING) && ACTIVE_CH[1] |-> scnt_q == exp_settle)
    else $error("settle length wrong");
  settle_first_a: assert property (
    $fell(SETTLING) |-> CONV_BEGIN) else $error("no start after settle");
  begin_pulse_a: assert property (
    CONV_BEGIN == $rose(CONVERTING)) else $error("begin pulse misplaced");
  phase_excl_a: assert property (
    !(SETTLING && CONVERTING)) else $error("phases overlap");
  start_lat_a: assert property (
    $rose(SETTLING) |-> $past(CONV_START, 2)) else $error("bad start");
  active_hold_a: assert property (
    !$rose(SETTLING) |-> $stable(ACTIVE_INTERVAL) &&
    $stable(ACTIVE_OFFSET) && $stable(ACTIVE_CH))
    else $error("captured value changed");
  fault_set_a: assert property (
    (AMP_FAULTS & ~$past(AMP_FAULTS)) != 4'h0 |-> $past(CONV_BEGIN) &&
    $past(AMP_FAULT_EN, 2) &&
    (AMP_FAULTS & ~$past(AMP_FAULTS)) == (4'h1 << ACTIVE_CH))
    else $error("fault flag wrong");

  // Main scenarios
  cover property ($fell(CONVERTING));
  cover property (CONV_DONE && ACTIVE_CH == 2'h3);
  cover property ($rose(AMP_FAULTS[2]));
endmodule : sctc_monitor

bind sctc_top sctc_monitor sctc_monitor_inst (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .CONV_START(CONV_START),
  .CH2_SETTLE(CH2_SETTLE), .CH3_SETTLE(CH3_SETTLE),
  .AMP_FAULT_EN(AMP_FAULT_EN), .SETTLING(SETTLING),
  .CONVERTING(CONVERTING), .CONV_BEGIN(CONV_BEGIN),
  .CONV_DONE(CONV_DONE), .ACTIVE_CH(ACTIVE_CH),
  .ACTIVE_OFFSET(ACTIVE_OFFSET), .ACTIVE_INTERVAL(ACTIVE_INTERVAL),
  .AMP_FAULTS(AMP_FAULTS));

`default_nettype wire

// file: sctc_pkg.sv
// Constants, register map and state types for the sensor channel
// timing and offset configuration block.
// Assumes one 100 MHz clock that also serves as the reference clock.
//
// Notes on behaviour
// - A conversion lasts sixteen reference periods per unit of the channel's interval count.
// - Interval counts of channels one to three reset to 0x0080 and are read and written by the host.
// - The active channel's offset word, worth offset over two to the sixteenth times the reference frequency, is handed to the datapath.
// - All four offset words reset to zero and are read and written by the host.
// - Every conversion is preceded by the channel's settling wait.
// - Settling lasts 32 periods for counts zero and one, else count times sixteen periods, and counts of channels zero and one reset to zero.
// - An unsettled amplitude at conversion start raises that channel's amplitude fault when fault reporting is enabled.
// - The amplitude fault shows in bit 12 of the channel's result high word and clears when that word is read.

package sctc_pkg;

  localparam int DW = 16;

  // Register offsets
  localparam logic [7:0] ADDR_CH1_INTERVAL = 8'h09;
  localparam logic [7:0] ADDR_CH2_INTERVAL = 8'h0A;
  localparam logic [7:0] ADDR_CH3_INTERVAL = 8'h0B;
  localparam logic [7:0] ADDR_CH0_OFFSET   = 8'h0C;
  localparam logic [7:0] ADDR_CH1_OFFSET   = 8'h0D;
  localparam logic [7:0] ADDR_CH2_OFFSET   = 8'h0E;
  localparam logic [7:0] ADDR_CH3_OFFSET   = 8'h0F;
  localparam logic [7:0] ADDR_CH0_SETTLE   = 8'h10;
  localparam logic [7:0] ADDR_CH1_SETTLE   = 8'h11;
  localparam logic [7:0] ADDR_DATA_HI_LAST = 8'h06;

  // Config words held in the array, first index and count
  localparam int CFG_COUNT      = 9;
  localparam int CFG_INTERVALS  = 3;
  localparam int CFG_CH0_FREQUENCY_OFFSET    = 3;
  localparam int CFG_SETTLE0    = 7;
  localparam int CFG_SETTLE1    = 8;

  // Reset values
  localparam logic [15:0] INTERVAL_RESET = 16'h0080;
  localparam logic [15:0] OFFSET_RESET   = 16'h0000;
  localparam logic [15:0] SETTLE_RESET   = 16'h0000;

  // Result high word field
  localparam int AMP_FAULT_BIT = 12;

  // Serial slave address, value arbitrary
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2C;

  // Timing
  localparam int CLK_PERIOD_NS       = 10;
  localparam int REF_PERIOD_NS       = 10;
  localparam int CLK_PER_REF         =
    (REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PERIODS_PER_COUNT   = 16;
  localparam int CYC_PER_COUNT       = PERIODS_PER_COUNT * CLK_PER_REF;
  localparam int SETTLE_MIN_PERIODS  = 32;
  localparam int SETTLE_MIN_CYC      = SETTLE_MIN_PERIODS * CLK_PER_REF;
  localparam logic [15:0] SETTLE_MIN_COUNT = 16'h0002;
  localparam int CW                  = 22;

  typedef enum logic [2:0] {
    SCTC_I_IDLE, SCTC_I_ADDR, SCTC_I_ACK, SCTC_I_PTR,
    SCTC_I_WHI, SCTC_I_WLO, SCTC_I_RD, SCTC_I_MACK
  } sctc_i2c_state_t;

  typedef enum logic [1:0] {
    SCTC_T_IDLE, SCTC_T_SETTLE, SCTC_T_CONV
  } sctc_tmr_state_t;

endpackage : sctc_pkg

// file: sctc_timer.sv
// Settle-then-convert interval timer for one active channel.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/100ps
`default_nettype none

module sctc_timer (
  input  wire logic                  clk,          // Reference clock
  input  wire logic                  rst_n,        // Sync reset, low
  input  wire logic                  start,        // Begin settling
  input  wire logic [sctc_pkg::CW-1:0] settle_cyc, // Settle length
  input  wire logic [sctc_pkg::CW-1:0] conv_cyc,   // Conversion length
  output logic                       settling_q,   // Settle phase
  output logic                       converting_q, // Conversion phase
  output logic                       begin_q,      // Conversion start
  output logic                       done_q        // Conversion end
);

  sctc_pkg::sctc_tmr_state_t state_q;
  logic [sctc_pkg::CW-1:0]   cnt_q;
  logic [sctc_pkg::CW-1:0]   conv_q;
  wire                       cnt_zero = (cnt_q == '0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= sctc_pkg::SCTC_T_IDLE;
      cnt_q   <= '0;
      conv_q  <= '0;
      begin_q <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      begin_q <= 1'b0;
      done_q  <= 1'b0;
      unique case (state_q)
        sctc_pkg::SCTC_T_IDLE: begin
          if (start) begin
            state_q <= sctc_pkg::SCTC_T_SETTLE;
            cnt_q   <= settle_cyc - 1'b1;
            conv_q  <= conv_cyc;
          end
        end
        sctc_pkg::SCTC_T_SETTLE: begin
          if (cnt_zero) begin
            state_q <= sctc_pkg::SCTC_T_CONV;
            cnt_q   <= conv_q - 1'b1;
            begin_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        sctc_pkg::SCTC_T_CONV: begin
          if (cnt_zero) begin
            state_q <= sctc_pkg::SCTC_T_IDLE;
            done_q  <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        // Spare state code falls back to idle
        default: state_q <= sctc_pkg::SCTC_T_IDLE;
      endcase
    end
  end

  // Phase flags from state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settling_q   <= 1'b0;
      converting_q <= 1'b0;
    end else begin
      settling_q   <= (state_q == sctc_pkg::SCTC_T_IDLE) ? start :
                      (state_q == sctc_pkg::SCTC_T_SETTLE) && !cnt_zero;
      converting_q <= (state_q == sctc_pkg::SCTC_T_SETTLE) ? cnt_zero :
                      (state_q == sctc_pkg::SCTC_T_CONV) && !cnt_zero;
    end
  end

endmodule : sctc_timer

`default_nettype wire

// file: sctc_top.sv
// Channel timing/offset configuration with its serial register port.
// Assumes an I2C-style two-wire host; SCL and SDA come from pins.
`timescale 1ns/100ps
`default_nettype none

module sctc_top (
  input  wire logic        REF_CLK,         // 100 MHz clock
  input  wire logic        RST_N,           // Sync reset, low
  input  wire logic        SCL,             // Serial clock pin
  input  wire logic        SDA_IN,          // Serial data level
  output logic             SDA_OUT,         // Serial data drive
  output logic             SDA_OE,          // High while pulling low
  input  wire logic        CONV_START,      // Request one conversion
  input  wire logic [1:0]  CONV_CH,         // Channel of request
  input  wire logic [15:0] CH0_INTERVAL,    // Channel 0 interval count
  input  wire logic [15:0] CH2_SETTLE,      // Channel 2 settle count
  input  wire logic [15:0] CH3_SETTLE,      // Channel 3 settle count
  input  wire logic        AMP_SETTLED,     // Sensor amplitude settled
  input  wire logic        AMP_FAULT_EN,    // Report amplitude faults
  output logic             SETTLING,        // Settle phase active
  output logic             CONVERTING,      // Conversion active
  output logic             CONV_BEGIN,      // Conversion start pulse
  output logic             CONV_DONE,       // Conversion end pulse
  output logic [1:0]       ACTIVE_CH,       // Captured channel
  output logic [15:0]      ACTIVE_OFFSET,   // Captured offset word
  output logic [15:0]      ACTIVE_INTERVAL, // Captured interval count
  output logic [3:0]       AMP_FAULTS       // Amplitude fault flags
);

  localparam logic [6:0] SLAVE_ADDR = sctc_pkg::SLAVE_ADDR_DEFAULT;

  // Pin synchronisers, three stages each
  logic scl_s1_q, scl_s2_q, scl_s3_q, scl_lvl_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q, sda_lvl_q;
  logic amp_s1_q, amp_s2_q, amp_s3_q, amp_lvl_q;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
      {amp_s1_q, amp_s2_q, amp_s3_q} <= 3'h0;
    end else begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= {SCL, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_s3_q} <= {SDA_IN, sda_s1_q, sda_s2_q};
      {amp_s1_q, amp_s2_q, amp_s3_q} <= {AMP_SETTLED, amp_s1_q, amp_s2_q};
    end
  end

  // Accepted level once stages two and three agree
  wire scl_upd = (scl_s2_q == scl_s3_q) && (scl_s3_q != scl_lvl_q);
  wire sda_upd = (sda_s2_q == sda_s3_q) && (sda_s3_q != sda_lvl_q);
  wire scl_rise = scl_upd && scl_s3_q;
  wire scl_fall = scl_upd && !scl_s3_q;
  wire bus_start = sda_upd && !sda_s3_q && scl_lvl_q && !scl_upd;
  wire bus_stop  = sda_upd && sda_s3_q && scl_lvl_q && !scl_upd;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      scl_lvl_q <= 1'b1;
      sda_lvl_q <= 1'b1;
      amp_lvl_q <= 1'b0;
    end else begin
      if (scl_s2_q == scl_s3_q) scl_lvl_q <= scl_s3_q;
      if (sda_s2_q == sda_s3_q) sda_lvl_q <= sda_s3_q;
      if (amp_s2_q == amp_s3_q) amp_lvl_q <= amp_s3_q;
    end
  end

  // Register port state
  sctc_pkg::sctc_i2c_state_t st_q, nxt_q;
  logic [3:0]  cnt_q;
  logic [7:0]  sh_q;
  logic [7:0]  ptr_q;
  logic [7:0]  wbuf_q;
  logic [15:0] rd_word_q;
  logic        hi_q;
  logic        oe_q;
  logic        wr_stb_q;
  logic [7:0]  wr_addr_q;
  logic [15:0] wr_data_q;
  logic        rd_clr_q;
  logic [7:0]  rd_addr_q;

  logic [15:0] cfg_q [sctc_pkg::CFG_COUNT];
  logic [3:0]  amp_q;

  // Read selection by pointer
  wire [7:0]  cfg_off  = ptr_q - sctc_pkg::ADDR_CH1_INTERVAL;
  wire [3:0]  cfg_idx  = cfg_off[3:0];
  wire        cfg_hit  = (ptr_q >= sctc_pkg::ADDR_CH1_INTERVAL) &&
                         (ptr_q <= sctc_pkg::ADDR_CH1_SETTLE);
  wire        data_hi  = (ptr_q <= sctc_pkg::ADDR_DATA_HI_LAST) && !ptr_q[0];
  wire [15:0] fault_w  = 16'(amp_q[ptr_q[2:1]]) << sctc_pkg::AMP_FAULT_BIT;
  wire [15:0] rd_mux   = cfg_hit ? cfg_q[cfg_idx] :
                         data_hi ? fault_w : 16'h0000;
  wire [7:0]  tx_byte  = hi_q ? rd_word_q[15:8] : rd_word_q[7:0];
  wire [2:0]  tx_sel   = 3'(4'h7 - cnt_q);
  wire        addr_ok  = (sh_q[7:1] == SLAVE_ADDR);

  // Byte-level serial slave, auto-incrementing pointer
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      st_q      <= sctc_pkg::SCTC_I_IDLE;
      nxt_q     <= sctc_pkg::SCTC_I_IDLE;
      cnt_q     <= 4'h0;
      sh_q      <= 8'h00;
      ptr_q     <= 8'h00;
      wbuf_q    <= 8'h00;
      rd_word_q <= 16'h0000;
      hi_q      <= 1'b1;
      oe_q      <= 1'b0;
      wr_stb_q  <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 16'h0000;
      rd_clr_q  <= 1'b0;
      rd_addr_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      rd_clr_q <= 1'b0;
      if (bus_start) begin
        st_q  <= sctc_pkg::SCTC_I_ADDR;
        cnt_q <= 4'h0;
        oe_q  <= 1'b0;
      end else if (bus_stop) begin
        st_q <= sctc_pkg::SCTC_I_IDLE;
        oe_q <= 1'b0;
      end else begin
        unique case (st_q)
          sctc_pkg::SCTC_I_IDLE: ;
          sctc_pkg::SCTC_I_ADDR, sctc_pkg::SCTC_I_PTR,
          sctc_pkg::SCTC_I_WHI, sctc_pkg::SCTC_I_WLO: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_lvl_q};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              oe_q <= 1'b1;
              st_q <= sctc_pkg::SCTC_I_ACK;
              if (st_q == sctc_pkg::SCTC_I_ADDR) begin
                nxt_q <= sh_q[0] ? sctc_pkg::SCTC_I_RD : sctc_pkg::SCTC_I_PTR;
                if (!addr_ok) begin
                  oe_q <= 1'b0;
                  st_q <= sctc_pkg::SCTC_I_IDLE;
                end else if (sh_q[0]) begin
                  rd_word_q <= rd_mux;
                  rd_clr_q  <= 1'b1;
                  rd_addr_q <= ptr_q;
                  ptr_q     <= ptr_q + 8'h01;
                  hi_q      <= 1'b1;
                end
              end else if (st_q == sctc_pkg::SCTC_I_PTR) begin
                ptr_q <= sh_q;
                nxt_q <= sctc_pkg::SCTC_I_WHI;
              end else if (st_q == sctc_pkg::SCTC_I_WHI) begin
                wbuf_q <= sh_q;
                nxt_q  <= sctc_pkg::SCTC_I_WLO;
              end else begin
                wr_stb_q  <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= {wbuf_q, sh_q};
                ptr_q     <= ptr_q + 8'h01;
                nxt_q     <= sctc_pkg::SCTC_I_WHI;
              end
            end
          end
          sctc_pkg::SCTC_I_ACK: begin
            if (scl_fall) begin
              cnt_q <= 4'h0;
              st_q  <= nxt_q;
              oe_q  <= (nxt_q == sctc_pkg::SCTC_I_RD) ? !tx_byte[7] : 1'b0;
            end
          end
          sctc_pkg::SCTC_I_RD: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == 4'h8) begin
                oe_q <= 1'b0;
                st_q <= sctc_pkg::SCTC_I_MACK;
              end else begin
                oe_q <= !tx_byte[tx_sel];
              end
            end
          end
          sctc_pkg::SCTC_I_MACK: begin
            if (scl_rise) begin
              if (sda_lvl_q) begin
                st_q <= sctc_pkg::SCTC_I_IDLE;
              end else if (hi_q) begin
                hi_q <= 1'b0;
              end else begin
                rd_word_q <= rd_mux;
                rd_clr_q  <= 1'b1;
                rd_addr_q <= ptr_q;
                ptr_q     <= ptr_q + 8'h01;
                hi_q      <= 1'b1;
              end
            end else if (scl_fall) begin
              cnt_q <= 4'h0;
              st_q  <= sctc_pkg::SCTC_I_RD;
              oe_q  <= !tx_byte[7];
            end
          end
        endcase
      end
    end
  end

  // Open-drain data pin, only ever pulls low
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      SDA_OUT <= 1'b0;
    end else begin
      SDA_OUT <= 1'b0;
    end
  end
  assign SDA_OE = oe_q;

  // Config words: intervals, offsets, settle counts
  genvar g;
  generate
    for (g = 0; g < sctc_pkg::CFG_COUNT; g++) begin : g_cfg
      localparam logic [15:0] RV =
        (g < sctc_pkg::CFG_INTERVALS) ? sctc_pkg::INTERVAL_RESET :
        (g < sctc_pkg::CFG_SETTLE0)   ? sctc_pkg::OFFSET_RESET :
                                        sctc_pkg::SETTLE_RESET;
      wire hit = wr_stb_q &&
                 (wr_addr_q == sctc_pkg::ADDR_CH1_INTERVAL + 8'(g));
      always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
          cfg_q[g] <= RV;
        end else if (hit) begin
          cfg_q[g] <= wr_data_q;
        end
      end
    end
  endgenerate

  // Timer handshake signals
  logic tmr_settling, tmr_converting, tmr_begin, tmr_done;
  logic busy_q;
  logic [1:0]  ch_q;
  logic [15:0] off_q;
  logic [15:0] int_q;

  // Per-channel selection at request time
  wire [15:0] int_sel =
    (CONV_CH == 2'h0) ? CH0_INTERVAL : cfg_q[4'(CONV_CH) - 4'h1];
  wire [15:0] off_sel = cfg_q[4'(sctc_pkg::CFG_CH0_FREQUENCY_OFFSET) + 4'(CONV_CH)];
  wire [15:0] set_sel =
    (CONV_CH == 2'h0) ? cfg_q[sctc_pkg::CFG_SETTLE0] :
    (CONV_CH == 2'h1) ? cfg_q[sctc_pkg::CFG_SETTLE1] :
    (CONV_CH == 2'h2) ? CH2_SETTLE : CH3_SETTLE;

  wire [31:0] set_prod = 32'(set_sel) * sctc_pkg::CYC_PER_COUNT;
  wire [sctc_pkg::CW-1:0] settle_cyc =
    (set_sel < sctc_pkg::SETTLE_MIN_COUNT) ?
      sctc_pkg::CW'(sctc_pkg::SETTLE_MIN_CYC) : set_prod[sctc_pkg::CW-1:0];
  wire [31:0] conv_prod = 32'(int_sel) * sctc_pkg::CYC_PER_COUNT;
  wire [sctc_pkg::CW-1:0] conv_cyc = conv_prod[sctc_pkg::CW-1:0];
  wire start_ok = CONV_START && !busy_q;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      busy_q <= 1'b0;
      ch_q   <= 2'h0;
      off_q  <= 16'h0000;
      int_q  <= 16'h0000;
    end else begin
      busy_q <= (busy_q && !tmr_done) || start_ok;
      if (start_ok) begin
        ch_q  <= CONV_CH;
        off_q <= off_sel;
        int_q <= int_sel;
      end
    end
  end

  sctc_timer u_timer (
    .clk          (REF_CLK),
    .rst_n        (RST_N),
    .start        (start_ok),
    .settle_cyc   (settle_cyc),
    .conv_cyc     (conv_cyc),
    .settling_q   (tmr_settling),
    .converting_q (tmr_converting),
    .begin_q      (tmr_begin),
    .done_q       (tmr_done)
  );

  // Amplitude fault flags, set wins over read clear
  generate
    for (g = 0; g < 4; g++) begin : g_amp
      wire set_f = tmr_begin && (ch_q == 2'(g)) &&
                   !amp_lvl_q && AMP_FAULT_EN;
      wire clr_f = rd_clr_q &&
                   (rd_addr_q == 8'(2 * g));
      always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
          amp_q[g] <= 1'b0;
        end else begin
          amp_q[g] <= set_f || (amp_q[g] && !clr_f);
        end
      end
    end
  endgenerate

  // Registered status outputs
  // captured offset to datapath
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      SETTLING        <= 1'b0;
      CONVERTING      <= 1'b0;
      CONV_BEGIN      <= 1'b0;
      CONV_DONE       <= 1'b0;
      ACTIVE_CH       <= 2'h0;
      ACTIVE_OFFSET   <= 16'h0000;
      ACTIVE_INTERVAL <= 16'h0000;
      AMP_FAULTS      <= 4'h0;
    end else begin
      SETTLING        <= tmr_settling;
      CONVERTING      <= tmr_converting;
      CONV_BEGIN      <= tmr_begin;
      CONV_DONE       <= tmr_done;
      ACTIVE_CH       <= ch_q;
      ACTIVE_OFFSET   <= off_q;
      ACTIVE_INTERVAL <= int_q;
      AMP_FAULTS      <= amp_q;
    end
  end

endmodule : sctc_top

`default_nettype wire

// file: sctc_top_tb.sv
// Bench: register access over the two-wire port and timed conversions.
// Assumes one 100 MHz clock; the host model drives SCL and SDA.
`timescale 1ns/100ps
`default_nettype none

module sctc_top_tb;
  logic        ref_clk, rst_n, conv_start, amp_ok, fault_en, ack;
  logic        scl, sda_drv, sda_out, sda_oe, settling, converting;
  logic [1:0]  conv_ch, act_ch;
  logic [15:0] ch0_int, ch2_set, ch3_set, act_off, act_int, rdat;
  logic [3:0]  faults;
  int          err_count, checks, cyc;
  wire         sda_wire = sda_drv & (sda_oe ? sda_out : 1'b1);

  sctc_top sctc_top_inst (
    .REF_CLK(ref_clk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda_wire),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .CONV_START(conv_start),
    .CONV_CH(conv_ch), .CH0_INTERVAL(ch0_int), .CH2_SETTLE(ch2_set),
    .CH3_SETTLE(ch3_set), .AMP_SETTLED(amp_ok), .AMP_FAULT_EN(fault_en),
    .SETTLING(settling), .CONVERTING(converting), .CONV_BEGIN(),
    .CONV_DONE(), .ACTIVE_CH(act_ch), .ACTIVE_OFFSET(act_off),
    .ACTIVE_INTERVAL(act_int), .AMP_FAULTS(faults));

  sctc_host_model sctc_host_model_inst (
    .clk(ref_clk), .scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire));

  // Clock and hang guard
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      tally_and_finish;
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Register pattern: small counts, rich offsets
  function automatic logic [15:0] pat(input logic [7:0] a);
    return (a < 8'h0C || a > 8'h0F) ? {8'h00, a} : {a, ~a};
  endfunction : pat

  // One conversion, measuring both phases in cycles
  task automatic conv(input logic [1:0] ch, input int es, input int ec,
                      input logic [15:0] eo, input logic [15:0] ei);
    int s;
    int c;
    s = 0;
    c = 0;
    @(posedge ref_clk);
    conv_start <= 1'b1;
    conv_ch <= ch;
    @(posedge ref_clk);
    conv_start <= 1'b0;
    while (settling !== 1'b1 && c < 8) begin
      @(negedge ref_clk);
      c++;
    end
    c = 0;
    while (settling === 1'b1 && s < 2000) begin
      s++;
      @(negedge ref_clk);
    end
    while (converting === 1'b1 && c < 5000) begin
      c++;
      @(negedge ref_clk);
    end
    chk(s, es);
    chk(c, ec);
    chk(32'(act_off), 32'(eo));
    chk(32'(act_int), 32'(ei));
    chk(32'(act_ch), 32'(ch));
  endtask : conv

  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    conv_start = 1'b0;
    conv_ch = 2'h0;
    amp_ok = 1'b1;
    fault_en = 1'b1;
    ch0_int = 16'h0006;
    ch2_set = 16'h0000;
    ch3_set = 16'h0001;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    for (logic [7:0] a = 8'h09; a <= 8'h11; a++) begin
      sctc_host_model_inst.rd(a, rdat);
      chk(32'(rdat), (a < 8'h0C) ? 32'h80 : 32'h0);
    end
    for (logic [7:0] a = 8'h09; a <= 8'h11; a++) begin
      sctc_host_model_inst.wr(a, pat(a));
    end
    for (logic [7:0] a = 8'h09; a <= 8'h11; a++) begin
      sctc_host_model_inst.rd(a, rdat);
      chk(32'(rdat), 32'(pat(a)));
    end
    // Unmapped place and foreign slave address
    sctc_host_model_inst.wr(8'h20, 16'hFFFF);
    sctc_host_model_inst.rd(8'h20, rdat);
    chk(32'(rdat), 32'h0);
    sctc_host_model_inst.probe(8'h5A, ack);
    chk(32'(ack), 32'h0);
    // Interval rewritten mid-conversion applies only later
    fork
      conv(2'h1, 272, 144, 16'h0DF2, 16'h0009);
      sctc_host_model_inst.wr(sctc_pkg::ADDR_CH1_INTERVAL, 16'h0005);
    join
    sctc_host_model_inst.wr(sctc_pkg::ADDR_CH1_SETTLE, 16'h0002);
    conv(2'h1, 32, 80, 16'h0DF2, 16'h0005);
    conv(2'h0, 256, 96, 16'h0CF3, 16'h0006);
    chk(32'(faults), 32'h0);
    @(posedge ref_clk);
    amp_ok <= 1'b0;
    conv(2'h2, 32, 160, 16'h0EF1, 16'h000A);
    repeat (3) @(negedge ref_clk);
    chk(32'(faults), 32'h4);
    @(posedge ref_clk);
    fault_en <= 1'b0;
    conv(2'h3, 32, 176, 16'h0FF0, 16'h000B);
    repeat (3) @(negedge ref_clk);
    chk(32'(faults), 32'h4);
    sctc_host_model_inst.rd(8'h04, rdat);
    chk(32'(rdat[12]), 32'h1);
    chk(32'(faults), 32'h0);
    sctc_host_model_inst.rd(8'h04, rdat);
    chk(32'(rdat[12]), 32'h0);
    // Second reset restores defaults
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    sctc_host_model_inst.rd(sctc_pkg::ADDR_CH1_INTERVAL, rdat);
    chk(32'(rdat), 32'h80);
    sctc_host_model_inst.rd(sctc_pkg::ADDR_CH1_OFFSET, rdat);
    chk(32'(rdat), 32'h0);
    tally_and_finish;
  end
endmodule : sctc_top_tb

`default_nettype wire
